// >>> logic/gtu_defines.svh
// register offsets, field positions, reset values and counts of the timer unit
// Notes on behaviour
// - five 16-bit up/down timers: three in the first module, two in the second
// - timers run alone or chain only to a timer of their own module
// - first-module timers select timer, gated, counter or incremental mode
// - timer mode advances at system clock divided by the programmed prescaler
// - counter mode advances on selected edges of the timer's count pin
// - gated mode counts prescaled clocks only while the gate pin is high
// - in timer or gated mode, timers advance at most once every 4 system clocks
// - direction from a control bit, optionally flipped by the direction pin
// - incremental mode derives count and direction from quadrature pins
// - core timer a toggles its latch on each wrap; latch may drive a pin
// - core a latch may clock both auxiliary timers of the first module
// - an auxiliary timer used as capture or reload register does not count
// - capture mode latches core timer a on the selected pin edge
// - reload mode copies into core a on pin edge or latch transition
// - two reloads on opposite latch edges give a hands-free pwm waveform
// - core timer b toggles its latch, may clock aux c and drive a pin
// - core b wraps are output and may reload it from the capture register
// - capture register takes aux c on capture pin edge, optional clear
// - capture may instead trigger on core a count and/or direction pins
`ifndef GTU_DEFINES_SVH
`define GTU_DEFINES_SVH
`define GTU_CORE_A 0
`define GTU_AUX_A 1
`define GTU_AUX_B 2
`define GTU_CORE_B 3
`define GTU_AUX_C 4
`define GTU_DIR_BASE 5
`define GTU_CAP_PIN 10
`define GTU_REG_CTRL0 4'h0
`define GTU_REG_CNT0 4'h5
`define GTU_REG_CAPREG 4'ha
`define GTU_REG_CAPCTL 4'hb
`define GTU_REG_STATUS 4'hc
`define GTU_F_MODE 0
`define GTU_F_PRESC 3
`define GTU_F_RUN 6
`define GTU_F_DOWN 7
`define GTU_F_EXTDIR 8
`define GTU_F_OUTEN 9
`define GTU_F_EDGE 10
`define GTU_F_ALTSRC 12
`define GTU_F_LATTRIG 13
`define GTU_CC_EN 0
`define GTU_CC_EDGE 1
`define GTU_CC_SRC 3
`define GTU_CC_CLEAR 5
`define GTU_CTRL_RST 16'h0000
`define GTU_CNT_RST 16'h0000
`define GTU_CAP_RST 16'h0000
`define GTU_MIN_DIV 4
`endif

// >>> logic/gtu_pkg.sv
// types shared by the general timer unit
package gtu_pkg;
  typedef enum logic [2:0] {
    GTU_TIMER,
    GTU_GATED,
    GTU_COUNTER,
    GTU_INCR,
    GTU_RELOAD,
    GTU_CAPTURE
  } gtu_mode_e;

  typedef struct packed {
    logic capture;
    logic [4:0] direction;
    logic [4:0] count_gate;
  } gtu_pins_s;

  typedef struct packed {
    logic [4:0][15:0] ctrl;
    logic [4:0][15:0] cnt;
    logic [15:0] capreg;
    logic [15:0] capctl;
    logic [15:0] rdata;
    logic [10:0] s1;
    logic [10:0] s2;
    logic [10:0] s3;
    logic [10:0] q;
    logic [8:0] pre;
    logic latch_a;
    logic latch_b;
    logic lat_a_d;
    logic lat_b_d;
    logic wrap_b;
  } gtu_state_s;
endpackage

// >>> logic/gtu_timer_unit.sv
// general timer unit: five 16-bit timers in two modules with register port
`timescale 1ns/1ns
`include "gtu_defines.svh"
module gtu_timer_unit (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire gtu_pkg::gtu_pins_s timer_pins,
  output logic core_a_toggle_pin,
  output logic core_a_toggle_oe,
  output logic core_b_toggle_pin,
  output logic core_b_toggle_oe,
  output logic core_b_wrap
);
  import gtu_pkg::*;

  gtu_state_s st_ff;
  gtu_state_s nxt_st;
  gtu_mode_e mode [5];
  logic [10:0] rise;
  logic [10:0] fall;
  logic [4:0] tick;
  logic [4:0] adv;
  logic [4:0] dn;
  logic [4:0] wrap;
  logic [4:0] src_hit;
  logic [2:1] cap_hit;
  logic [2:1] rel_hit;
  logic cr_hit;
  logic lat_a_r;
  logic lat_a_f;
  logic lat_b_r;
  logic lat_b_f;
  logic a_edge;
  logic b_edge;

  function automatic logic edge_hit(logic [1:0] sel, logic r, logic f);
    return (sel[0] & r) | (sel[1] & f);
  endfunction

  // every divider is a multiple of four, so the finest step is four clocks
  function automatic logic pre_tick(logic [8:0] pre, logic [2:0] ps);
    logic [8:0] mask;
    mask = 9'((`GTU_MIN_DIV << ps) - 1);
    return (pre & mask) == mask;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    rise = '0;
    fall = '0;
    tick = '0;
    adv = '0;
    dn = '0;
    wrap = '0;
    src_hit = '0;
    cap_hit = '0;
    rel_hit = '0;
    cr_hit = 1'b0;
    a_edge = 1'b0;
    b_edge = 1'b0;
    for (int i = 0; i < 5; i++) begin
      mode[i] = gtu_mode_e'(st_ff.ctrl[i][`GTU_F_MODE +: 3]);
    end

    // three stages; a level counts once stages two and three agree
    nxt_st.s1 = timer_pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int k = 0; k < 11; k++) begin
      if (st_ff.s2[k] == st_ff.s3[k]) begin
        nxt_st.q[k] = st_ff.s3[k];
      end
    end
    rise = nxt_st.q & ~st_ff.q;
    fall = ~nxt_st.q & st_ff.q;

    nxt_st.pre = st_ff.pre + 9'h001;
    nxt_st.lat_a_d = st_ff.latch_a;
    nxt_st.lat_b_d = st_ff.latch_b;
    nxt_st.wrap_b = 1'b0;
    // latch edges are seen one cycle late, which keeps the chain acyclic
    lat_a_r = st_ff.latch_a & ~st_ff.lat_a_d;
    lat_a_f = ~st_ff.latch_a & st_ff.lat_a_d;
    lat_b_r = st_ff.latch_b & ~st_ff.lat_b_d;
    lat_b_f = ~st_ff.latch_b & st_ff.lat_b_d;

    for (int i = 0; i < 5; i++) begin
      tick[i] = pre_tick(st_ff.pre, st_ff.ctrl[i][`GTU_F_PRESC +: 3]);
      if (st_ff.ctrl[i][`GTU_F_ALTSRC] && i == `GTU_AUX_C) begin
        src_hit[i] = edge_hit(st_ff.ctrl[i][`GTU_F_EDGE +: 2],
                              lat_b_r, lat_b_f);
      end else if (st_ff.ctrl[i][`GTU_F_ALTSRC] &&
                   (i == `GTU_AUX_A || i == `GTU_AUX_B)) begin
        src_hit[i] = edge_hit(st_ff.ctrl[i][`GTU_F_EDGE +: 2],
                              lat_a_r, lat_a_f);
      end else begin
        src_hit[i] = edge_hit(st_ff.ctrl[i][`GTU_F_EDGE +: 2],
                              rise[i], fall[i]);
      end
      dn[i] = st_ff.ctrl[i][`GTU_F_DOWN] ^
              (st_ff.ctrl[i][`GTU_F_EXTDIR] &
               nxt_st.q[i + `GTU_DIR_BASE]);
      unique case (mode[i])
        GTU_TIMER: adv[i] = tick[i];
        GTU_GATED: adv[i] = tick[i] & nxt_st.q[i];
        GTU_COUNTER: adv[i] = src_hit[i];
        GTU_INCR: begin
          // quadrature: a leading b counts up, b leading a counts down
          a_edge = rise[i] | fall[i];
          b_edge = rise[i + `GTU_DIR_BASE] | fall[i + `GTU_DIR_BASE];
          adv[i] = (i < 3) && (a_edge || b_edge);
          dn[i] = st_ff.ctrl[i][`GTU_F_DOWN] ^
                  (a_edge ? (nxt_st.q[i] == nxt_st.q[i + `GTU_DIR_BASE])
                          : (nxt_st.q[i] != nxt_st.q[i + `GTU_DIR_BASE]));
        end
        GTU_RELOAD: adv[i] = 1'b0;
        GTU_CAPTURE: adv[i] = 1'b0;
        default: adv[i] = 1'b0;
      endcase
      adv[i] = adv[i] & st_ff.ctrl[i][`GTU_F_RUN];
      if (adv[i]) begin
        wrap[i] = dn[i] ? (st_ff.cnt[i] == 16'h0000)
                        : (st_ff.cnt[i] == 16'hffff);
        nxt_st.cnt[i] = dn[i] ? st_ff.cnt[i] - 16'h0001
                              : st_ff.cnt[i] + 16'h0001;
      end
    end

    if (wrap[`GTU_CORE_A]) begin
      nxt_st.latch_a = ~st_ff.latch_a;
    end
    if (wrap[`GTU_CORE_B]) begin
      nxt_st.latch_b = ~st_ff.latch_b;
      nxt_st.wrap_b = 1'b1;
      if (st_ff.ctrl[`GTU_CORE_B][`GTU_F_ALTSRC]) begin
        nxt_st.cnt[`GTU_CORE_B] = st_ff.capreg;
      end
    end

    // aux a and b as capture or reload registers of core a
    for (int j = 1; j < 3; j++) begin
      cap_hit[j] = (mode[j] == GTU_CAPTURE) &&
                   edge_hit(st_ff.ctrl[j][`GTU_F_EDGE +: 2],
                            rise[j], fall[j]);
      if (cap_hit[j]) begin
        nxt_st.cnt[j] = st_ff.cnt[`GTU_CORE_A];
      end
      rel_hit[j] = (mode[j] == GTU_RELOAD) &&
                   (st_ff.ctrl[j][`GTU_F_LATTRIG] ?
                    edge_hit(st_ff.ctrl[j][`GTU_F_EDGE +: 2],
                             lat_a_r, lat_a_f) :
                    edge_hit(st_ff.ctrl[j][`GTU_F_EDGE +: 2],
                             rise[j], fall[j]));
      if (rel_hit[j]) begin
        // opposite latch edges on a and b give low and high times
        nxt_st.cnt[`GTU_CORE_A] = st_ff.cnt[j];
      end
    end

    // capture register trigger: own pin or the core a quadrature pins
    unique case (st_ff.capctl[`GTU_CC_SRC +: 2])
      2'h0: cr_hit = edge_hit(st_ff.capctl[`GTU_CC_EDGE +: 2],
                              rise[`GTU_CAP_PIN], fall[`GTU_CAP_PIN]);
      2'h1: cr_hit = rise[`GTU_CORE_A] | fall[`GTU_CORE_A];
      2'h2: cr_hit = rise[`GTU_DIR_BASE] | fall[`GTU_DIR_BASE];
      2'h3: cr_hit = rise[`GTU_CORE_A] | fall[`GTU_CORE_A] |
                     rise[`GTU_DIR_BASE] | fall[`GTU_DIR_BASE];
    endcase
    cr_hit = cr_hit & st_ff.capctl[`GTU_CC_EN];
    if (cr_hit) begin
      nxt_st.capreg = st_ff.cnt[`GTU_AUX_C];
      if (st_ff.capctl[`GTU_CC_CLEAR]) begin
        nxt_st.cnt[`GTU_AUX_C] = `GTU_CNT_RST;
      end
    end

    // software writes take precedence over hardware updates
    if (reg_write) begin
      if (reg_addr < `GTU_REG_CNT0) begin
        nxt_st.ctrl[reg_addr[2:0]] = reg_wdata;
      end else if (reg_addr < `GTU_REG_CAPREG) begin
        nxt_st.cnt[3'(reg_addr - `GTU_REG_CNT0)] = reg_wdata;
      end else if (reg_addr == `GTU_REG_CAPREG) begin
        nxt_st.capreg = reg_wdata;
      end else if (reg_addr == `GTU_REG_CAPCTL) begin
        nxt_st.capctl = reg_wdata;
      end
    end

    nxt_st.rdata = 16'h0000;
    if (reg_read) begin
      if (reg_addr < `GTU_REG_CNT0) begin
        nxt_st.rdata = st_ff.ctrl[reg_addr[2:0]];
      end else if (reg_addr < `GTU_REG_CAPREG) begin
        nxt_st.rdata = st_ff.cnt[3'(reg_addr - `GTU_REG_CNT0)];
      end else if (reg_addr == `GTU_REG_CAPREG) begin
        nxt_st.rdata = st_ff.capreg;
      end else if (reg_addr == `GTU_REG_CAPCTL) begin
        nxt_st.rdata = st_ff.capctl;
      end else if (reg_addr == `GTU_REG_STATUS) begin
        nxt_st.rdata = {3'h0, st_ff.q, st_ff.latch_b, st_ff.latch_a};
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign core_a_toggle_pin = st_ff.latch_a;
  assign core_a_toggle_oe = st_ff.ctrl[`GTU_CORE_A][`GTU_F_OUTEN];
  assign core_b_toggle_pin = st_ff.latch_b;
  assign core_b_toggle_oe = st_ff.ctrl[`GTU_CORE_B][`GTU_F_OUTEN];
  assign core_b_wrap = st_ff.wrap_b;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  chk_latch_a_toggle: assert property (
    wrap[`GTU_CORE_A] |=> st_ff.latch_a != $past(st_ff.latch_a))
    else $error("core a latch did not toggle on wrap");
  chk_latch_b_toggle: assert property (
    wrap[`GTU_CORE_B] |=> st_ff.latch_b != $past(st_ff.latch_b))
    else $error("core b latch did not toggle on wrap");
  chk_core_b_wrap: assert property (
    1'b1 |=> core_b_wrap == $past(wrap[`GTU_CORE_B]))
    else $error("core b wrap output not aligned to wrap");
  chk_reload_aux_stop: assert property (
    (mode[`GTU_AUX_B] == GTU_RELOAD && !reg_write)
    |=> $stable(st_ff.cnt[`GTU_AUX_B]))
    else $error("aux b counted in reload mode");
  chk_capture_value: assert property (
    (cap_hit[1] && !reg_write)
    |=> st_ff.cnt[`GTU_AUX_A] == $past(st_ff.cnt[`GTU_CORE_A]))
    else $error("aux a did not capture core a");
  chk_reload_value: assert property (
    (rel_hit[2] && !reg_write)
    |=> st_ff.cnt[`GTU_CORE_A] == $past(st_ff.cnt[`GTU_AUX_B]))
    else $error("core a not reloaded from aux b");
  chk_run_stop: assert property (
    (!st_ff.ctrl[`GTU_CORE_A][`GTU_F_RUN] && !reg_write &&
     !rel_hit[1] && !rel_hit[2])
    |=> $stable(st_ff.cnt[`GTU_CORE_A]))
    else $error("core a counted while stopped");
  chk_gate_hold: assert property (
    (mode[`GTU_CORE_A] == GTU_GATED && !nxt_st.q[`GTU_CORE_A] &&
     !reg_write && !rel_hit[1] && !rel_hit[2])
    |=> $stable(st_ff.cnt[`GTU_CORE_A]))
    else $error("core a counted with gate low");
  chk_wrap_up_value: assert property (
    (wrap[`GTU_CORE_A] && !dn[`GTU_CORE_A] && !reg_write &&
     !rel_hit[1] && !rel_hit[2])
    |=> st_ff.cnt[`GTU_CORE_A] == 16'h0000)
    else $error("core a did not wrap to zero");
  chk_wrap_down_value: assert property (
    (wrap[`GTU_CORE_A] && dn[`GTU_CORE_A] && !reg_write &&
     !rel_hit[1] && !rel_hit[2])
    |=> st_ff.cnt[`GTU_CORE_A] == 16'hffff)
    else $error("core a did not wrap to all ones");
  chk_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  chk_tick_spacing: assert property (
    tick[`GTU_CORE_A] |=> !tick[`GTU_CORE_A] [*3])
    else $error("core a ticked faster than every four clocks");
  chk_capreg_take: assert property (
    (cr_hit && !reg_write)
    |=> st_ff.capreg == $past(st_ff.cnt[`GTU_AUX_C]))
    else $error("capture register missed aux c value");
  chk_capreg_clear: assert property (
    (cr_hit && st_ff.capctl[`GTU_CC_CLEAR] && !reg_write)
    |=> st_ff.cnt[`GTU_AUX_C] == 16'h0000)
    else $error("aux c not cleared after capture");
  // a bit of q may move only to a value that stages two and three agreed on
  chk_sync_depth: assert property (
    $changed(st_ff.q) |->
    ((st_ff.q ^ $past(st_ff.q)) &
     (($past(st_ff.s2) ^ $past(st_ff.s3)) |
      ($past(st_ff.s3) ^ st_ff.q))) == 11'h000)
    else $error("synchronised level changed before stages agreed");

  cov_core_a_wrap: cover property (wrap[`GTU_CORE_A]);
  cov_capreg_hit: cover property (cr_hit);
  cov_pwm_cycle: cover property (rel_hit[1] ##[1:300] rel_hit[2]);
  cov_capture_hit: cover property (cap_hit[1]);
  cov_reload_hit: cover property (rel_hit[2]);
endmodule

// >>> verif/gtu_pin_model.sv
// model of the external count, gate, direction and encoder pins
`timescale 1ns/1ns
module gtu_pin_model (
  input wire logic core_clk,
  output gtu_pkg::gtu_pins_s pins
);
  import gtu_pkg::*;

  initial begin
    pins = '0;
  end

  // high levels stay 5 cycles and low levels 6 so the 3-flop synchroniser never merges edges
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge core_clk);
      pins[idx] <= 1'b1;
      repeat (5) @(posedge core_clk);
      pins[idx] <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
  endtask

  task automatic level(input int idx, input logic val);
    @(posedge core_clk);
    pins[idx] <= val;
  endtask

  // gray steps of an encoder: a on count pin 0, b on direction pin 5
  task automatic quad(input logic fwd, input int n);
    repeat (n) begin
      @(posedge core_clk);
      if ((pins[0] == pins[5]) == fwd) begin
        pins[0] <= ~pins[0];
      end else begin
        pins[5] <= ~pins[5];
      end
      repeat (5) @(posedge core_clk);
    end
  endtask
endmodule

// >>> verif/tb_gtu_timer_unit.sv
// self-checking bench of the general timer unit with random pin traffic
`timescale 1ns/1ns
module tb_gtu_timer_unit;
  import gtu_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  gtu_pins_s timer_pins;
  logic core_a_toggle_pin, core_a_toggle_oe, core_b_toggle_pin;
  logic core_b_toggle_oe, core_b_wrap;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int wraps = 0;
  int n;
  logic [31:0] seed = 32'd53;
  logic [15:0] a, b, v;
  logic [2:0] ps;
  logic down, gated, gate;

  gtu_timer_unit gtu_timer_unit_i (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timer_pins(timer_pins),
    .core_a_toggle_pin(core_a_toggle_pin),
    .core_a_toggle_oe(core_a_toggle_oe),
    .core_b_toggle_pin(core_b_toggle_pin),
    .core_b_toggle_oe(core_b_toggle_oe), .core_b_wrap(core_b_wrap));
  gtu_pin_model gtu_pin_model_i (.core_clk(core_clk), .pins(timer_pins));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (core_b_wrap === 1'b1) wraps <= wraps + 1;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // gated with a low gate holds; otherwise m steps in the set direction
  function automatic logic [15:0] tmr_exp(input logic g, input logic lvl,
      input logic dn, input int m);
    if (g && !lvl) return 16'h0000;
    return dn ? 16'(-m) : 16'(m);
  endfunction

  task automatic rnd();
    seed = xs(seed);
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (8) @(posedge core_clk);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i == 13) wr(4'hd, 16'hffff);
      rd(4'(i), v);
      chk("reset_or_unmapped", v, 16'h0000);
    end
    // read spacing is a whole number of periods, so the step is exact
    for (int k = 0; k < 6; k++) begin
      rnd();
      ps = {1'b0, seed[1:0]};
      down = seed[2];
      gated = seed[3];
      gate = seed[4];
      gtu_pin_model_i.level(0, gate);
      wr(4'h5, 16'h8000);
      wr(4'h0, {8'h00, down, 1'b1, ps, 2'b00, gated});
      n = 4 * (4 << ps);
      settle();
      rd(4'h5, a);
      repeat (n - 2) @(posedge core_clk);
      rd(4'h5, b);
      v = tmr_exp(gated, gate, down, 4);
      chk("timer_step", b - a, v);
    end
    gtu_pin_model_i.level(0, 1'b0);
    wr(4'h5, 16'hfffe);
    wr(4'h0, 16'h0240);
    repeat (40) @(posedge core_clk);
    v = {14'h0, core_a_toggle_oe, core_a_toggle_pin};
    chk("latch_a_up", v, 16'h0003);
    wr(4'h5, 16'h0001);
    wr(4'h0, 16'h02c0);
    repeat (40) @(posedge core_clk);
    v = {14'h0, core_a_toggle_oe, core_a_toggle_pin};
    chk("latch_a_down", v, 16'h0002);
    wr(4'h0, 16'h0200);
    wr(4'h5, 16'h0000);
    wr(4'h0, 16'h0442);
    rnd();
    n = seed[2:0] + 1;
    gtu_pin_model_i.pulse(0, n);
    settle();
    rd(4'h5, v);
    chk("count_up", v, 16'(n));
    wr(4'h0, 16'h0542);
    gtu_pin_model_i.level(5, 1'b1);
    settle();
    gtu_pin_model_i.pulse(0, n);
    settle();
    rd(4'h5, v);
    chk("count_pin_down", v, 16'h0000);
    gtu_pin_model_i.level(5, 1'b0);
    settle();
    wr(4'h5, 16'h0100);
    wr(4'h0, 16'h0043);
    rnd();
    n = seed[3:0] + 1;
    gtu_pin_model_i.quad(1'b1, n);
    settle();
    rd(4'h5, v);
    chk("encoder_fwd", v, 16'h0100 + 16'(n));
    gtu_pin_model_i.quad(1'b0, n);
    settle();
    rd(4'h5, v);
    chk("encoder_back", v, 16'h0100);
    wr(4'h0, 16'h0000);
    rnd();
    a = seed[15:0];
    wr(4'h5, a);
    wr(4'h1, 16'h0445);
    wr(4'h6, 16'h0000);
    gtu_pin_model_i.pulse(1, 1);
    settle();
    rd(4'h6, v);
    chk("capture_a", v, a);
    repeat (40) @(posedge core_clk);
    rd(4'h6, v);
    chk("capture_holds", v, a);
    rnd();
    b = seed[15:0];
    wr(4'h2, 16'h0444);
    wr(4'h7, b);
    gtu_pin_model_i.pulse(2, 1);
    settle();
    rd(4'h5, v);
    chk("reload_b", v, b);
    rnd();
    a = seed[15:0];
    wr(4'h9, a);
    wr(4'hb, 16'h0023);
    gtu_pin_model_i.pulse(10, 1);
    settle();
    rd(4'ha, v);
    chk("capreg", v, a);
    rd(4'h9, v);
    chk("aux_c_cleared", v, 16'h0000);
    wraps = 0;
    wr(4'h8, 16'hfffe);
    wr(4'h3, 16'h0240);
    repeat (40) @(posedge core_clk);
    wr(4'h3, 16'h0200);
    repeat (4) @(posedge core_clk);
    chk("core_b_wraps", 16'(wraps), 16'h0001);
    v = {14'h0, core_b_toggle_oe, core_b_toggle_pin};
    chk("latch_b", v, 16'h0003);
    rd(4'hc, v);
    chk("status_latches", {14'h0, v[1:0]}, 16'h0002);
    end_of_test();
  end
endmodule
